//--- logic/move_and_multiply_instr.sv
// Execution of the peripheral move, accumulator store and literal multiply
`timescale 1ns/1ps
`include "move_and_multiply_map.svh"
module move_and_multiply_instr
  import move_and_multiply_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // Instruction word, sampled in the decode phase
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  // Zero flag input from the rest of the core
  input  wire logic        i_zero_flag,
  // Data-space writes from the rest of the core
  input  wire logic        i_ext_we,
  input  wire logic [7:0]  i_ext_addr,
  input  wire logic [7:0]  i_ext_data,
  // Results
  output logic [7:0]       o_working_register,
  output logic [7:0]       o_multiply_result_high,
  output logic [7:0]       o_multiply_result_low,
  output logic             o_zero_flag,
  output logic             o_zero_flag_we,
  output logic             o_instr_done,
  output logic [1:0]       o_phase
);
  // ==========================================================
  // Phase sequencing
  phase_t phase;

  phase_sequencer u_seq (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .o_phase   (phase)
  );

  // ==========================================================
  // Data space and state
  // The whole 256-byte space lives here as plain flops: area was traded
  // for a single-cycle read and write with no port contention. Writes from
  // the rest of the core share the next-state logic with the instructions,
  // and an instruction's own write wins if both land in one write phase.
  // A pointer that names an indirect location is used as a plain address,
  // it is not followed a second time.
  logic [7:0]  mem_q [`DATA_DEPTH];
  logic [7:0]  mem_d [`DATA_DEPTH];
  op_t         op_q, op_d;
  logic [7:0]  src_q, src_d;
  logic [7:0]  dst_q, dst_d;
  logic [7:0]  lit_q, lit_d;
  logic [7:0]  opnd_q, opnd_d;
  logic [15:0] prod_q, prod_d;
  logic        zf_q, zf_d;
  logic        zwe_q, zwe_d;
  logic        done_q, done_d;

  // ==========================================================
  // Helpers
  // Indirect locations resolve through their pointer register
  function automatic logic [7:0] resolve(input logic [7:0] a,
                                         input logic [7:0] fsr0,
                                         input logic [7:0] fsr1);
    if (a == `ADDR_INDF0) begin
      resolve = fsr0;
    end else if (a == `ADDR_INDF1) begin
      resolve = fsr1;
    end else begin
      resolve = a;
    end
  endfunction : resolve

  // Opcode classification; an invalid word is never executed
  function automatic op_t classify(input logic [15:0] word,
                                   input logic        valid);
    if (!valid) begin
      classify = OP_NONE;
    end else if (word[15:13] == `MOVE_OPC_TOP) begin
      classify = OP_MOVE;
    end else if (word[15:8] == `STORE_OPC_HI) begin
      classify = OP_STORE;
    end else if (word[15:8] == `MULT_OPC_HI) begin
      classify = OP_MULT;
    end else begin
      // Every other opcode belongs to logic outside this block
      classify = OP_NONE;
    end
  endfunction : classify

  // Unsigned 8x8 product, both operands widened first so no bit is lost
  function automatic logic [15:0] product(input logic [7:0] a,
                                          input logic [7:0] b);
    product = {8'h00, a} * {8'h00, b};
  endfunction : product

  // ==========================================================
  // Instruction execution
  // Next state for decode, read, process and write phases
  always_comb begin
    mem_d  = mem_q;
    op_d   = op_q;
    src_d  = src_q;
    dst_d  = dst_q;
    lit_d  = lit_q;
    opnd_d = opnd_q;
    prod_d = prod_q;
    zf_d   = i_zero_flag;
    zwe_d  = 1'b0;
    done_d = 1'b0;
    // Writes from the rest of the core; applied first so that an
    // instruction write in this same cycle overrides them
    if (i_ext_we) begin
      mem_d[i_ext_addr] = i_ext_data;
    end
    unique case (phase)
      PH_DECODE: begin
        op_d = classify(i_instr, i_instr_valid);
        // Operand fields latched for the later phases
        unique case (op_d)
          OP_MOVE: begin
            src_d = {3'h0, i_instr[12:8]};
            dst_d = i_instr[7:0];
          end
          OP_STORE: begin
            src_d = `ADDR_WORK_REG;
            dst_d = i_instr[7:0];
          end
          OP_MULT: begin
            lit_d = i_instr[7:0];
          end
          OP_NONE: begin
            // Nothing to latch; lit keeps its value, src and dst still pass through the resolve below
          end
        endcase
        // Pointers resolved here so a write cannot alter its own address
        src_d = resolve(src_d, mem_q[`ADDR_FSR0], mem_q[`ADDR_FSR1]);
        dst_d = resolve(dst_d, mem_q[`ADDR_FSR0], mem_q[`ADDR_FSR1]);
      end
      PH_READ: begin
        // Working register is just another location
        opnd_d = mem_q[src_q];
      end
      PH_PROCESS: begin
        // Move and store carry their byte through untouched
        if (op_q == OP_MULT) begin
          prod_d = product(mem_q[`ADDR_WORK_REG], lit_q);
        end
      end
      PH_WRITE: begin
        done_d = (op_q != OP_NONE);
        unique case (op_q)
          OP_MOVE: begin
            mem_d[dst_q] = opnd_q;
            zf_d  = (opnd_q == `BYTE_RESET);
            zwe_d = 1'b1;
          end
          OP_STORE: begin
            // Working register was fetched in the read phase
            mem_d[dst_q] = opnd_q;
          end
          OP_MULT: begin
            // Working register untouched, no flags written
            // Both halves land at one edge so nobody sees a torn pair
            mem_d[`ADDR_RESULT_HI] = prod_q[15:8];
            mem_d[`ADDR_RESULT_LO] = prod_q[7:0];
          end
          OP_NONE: begin
            done_d = 1'b0;
          end
        endcase
      end
    endcase
  end

  // ==========================================================
  // Data space register; every byte clears so no stale pointer survives
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < `DATA_DEPTH; i++) begin
        mem_q[i] <= `BYTE_RESET;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // ==========================================================
  // Instruction state registers
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q   <= OP_NONE;
      src_q  <= `BYTE_RESET;
      dst_q  <= `BYTE_RESET;
      lit_q  <= `BYTE_RESET;
      opnd_q <= `BYTE_RESET;
      prod_q <= `PROD_RESET;
      zf_q   <= 1'b0;
      zwe_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      op_q   <= op_d;
      src_q  <= src_d;
      dst_q  <= dst_d;
      lit_q  <= lit_d;
      opnd_q <= opnd_d;
      prod_q <= prod_d;
      zf_q   <= zf_d;
      zwe_q  <= zwe_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // Outputs from flip-flops
  // Data-space views of the working register and product pair
  assign o_working_register     = mem_q[`ADDR_WORK_REG];
  assign o_multiply_result_high = mem_q[`ADDR_RESULT_HI];
  assign o_multiply_result_low  = mem_q[`ADDR_RESULT_LO];
  // Status and handshake pulses
  assign o_zero_flag            = zf_q;
  assign o_zero_flag_we         = zwe_q;
  assign o_instr_done           = done_q;
  assign o_phase                = phase;
endmodule : move_and_multiply_instr

//--- logic/move_and_multiply_map.svh
// Constants for the move and multiply instruction execution block
// Contract
// - Opcode 010 copies source byte to destination
// - Destination byte selects any of 256 locations
// - Five-bit source limited to 00h..1Fh
// - Working register usable as source or destination
// - Indirect locations resolve through pointer registers
// - Literal multiply: working register times literal
// - Full product stored; working register unchanged
// - High byte high, low byte low
// - Multiply changes no status flag
`ifndef MOVE_AND_MULTIPLY_MAP_SVH
`define MOVE_AND_MULTIPLY_MAP_SVH
// ==========================================================
// Opcode fields
`define MOVE_OPC_TOP        3'h2
`define STORE_OPC_HI        8'h01
`define MULT_OPC_HI         8'hBC
// ==========================================================
// Special data-space locations
`define ADDR_INDF0          8'h00
`define ADDR_FSR0           8'h01
`define ADDR_WORK_REG       8'h0A
`define ADDR_INDF1          8'h08
`define ADDR_FSR1           8'h09
`define ADDR_RESULT_LO      8'h18
`define ADDR_RESULT_HI      8'h19
// ==========================================================
// Reset values and data-space depth
`define BYTE_RESET          8'h00
`define PROD_RESET          16'h0000
`define DATA_DEPTH          256
`endif

//--- logic/move_and_multiply_pkg.sv
// Types shared by the move and multiply block
package move_and_multiply_pkg;
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_MOVE, OP_STORE, OP_MULT} op_t;
endpackage : move_and_multiply_pkg

//--- logic/phase_sequencer.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
module phase_sequencer
  import move_and_multiply_pkg::*;
(
  // Clock and reset
  input  wire logic   i_mclk,
  input  wire logic   i_reset_n,
  // Phase
  output phase_t      o_phase
);
  phase_t phase_q;
  phase_t phase_d;

  // Phases walk decode, read, process, write
  always_comb begin
    unique case (phase_q)
      PH_DECODE:  phase_d = PH_READ;
      PH_READ:    phase_d = PH_PROCESS;
      PH_PROCESS: phase_d = PH_WRITE;
      PH_WRITE:   phase_d = PH_DECODE;
    endcase
  end

  // Phase register
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_q <= PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign o_phase = phase_q;
endmodule : phase_sequencer

//--- test/move_and_multiply_monitor.sv
// Checker for the move and multiply block ports
`timescale 1ns/1ps
module move_and_multiply_monitor (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  // Observed ports
  input wire logic [15:0] i_instr,
  input wire logic        i_instr_valid,
  input wire logic        o_zero_flag_we,
  input wire logic        o_instr_done,
  input wire logic [7:0]  o_working_register,
  input wire logic [1:0]  o_phase
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Accepted instructions
  sequence s_take;
    o_phase == 2'h0 && i_instr_valid;
  endsequence
  sequence s_mov;
    s_take ##0 i_instr[15:13] == 3'h2;
  endsequence
  sequence s_mul;
    s_take ##0 i_instr[15:8] == 8'hBC;
  endsequence
  sequence s_sto;
    s_take ##0 i_instr[15:8] == 8'h01;
  endsequence
  // ==========================================================
  // Properties
  AST_PHASE_STEP: assert property (o_phase != 2'h0 |=> o_phase == $past(o_phase) + 2'h1)
    else $error("phase did not advance");
  AST_DONE_PULSE: assert property (o_instr_done |=> !o_instr_done)
    else $error("done longer than one cycle");
  AST_MOVE_DONE: assert property (s_mov |-> ##[1:5] o_instr_done)
    else $error("move did not complete");
  AST_MOVE_ZWE: assert property (s_mov |-> ##[1:5] o_zero_flag_we)
    else $error("move did not write zero flag");
  AST_MUL_DONE: assert property (s_mul |-> ##[1:5] o_instr_done)
    else $error("multiply did not complete");
  AST_MUL_NOZ: assert property (s_mul |-> ##2 !o_zero_flag_we [*4])
    else $error("multiply wrote zero flag");
  AST_MUL_KEEPW: assert property (s_mul |-> ##1 $stable(o_working_register) [*5])
    else $error("multiply changed working register");
  AST_STO_NOZ: assert property (s_sto |-> ##2 !o_zero_flag_we [*4])
    else $error("store wrote zero flag");
  AST_ZWE_DONE: assert property (o_zero_flag_we |-> o_instr_done)
    else $error("zero write outside completion");
endmodule : move_and_multiply_monitor

bind move_and_multiply_instr move_and_multiply_monitor mon_u (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
  .o_zero_flag_we(o_zero_flag_we), .o_instr_done(o_instr_done),
  .o_working_register(o_working_register), .o_phase(o_phase));

//--- test/tb_top.sv
// Directed testbench for the move and multiply block
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, i_instr_valid = 1'b0, i_zero_flag = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic i_ext_we = 1'b0;
  logic [7:0] i_ext_addr = 8'h00, i_ext_data = 8'h00;
  logic [7:0] w, ph, pl;
  logic z, zwe, dn;
  logic [1:0] phs;
  int errors = 0, checks = 0;
  // Clock of 4 ns
  always #2 i_mclk = ~i_mclk;
  move_and_multiply_instr dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_instr(i_instr),
    .i_ext_we(i_ext_we), .i_ext_addr(i_ext_addr), .i_ext_data(i_ext_data),
    .i_instr_valid(i_instr_valid), .i_zero_flag(i_zero_flag), .o_working_register(w),
    .o_multiply_result_high(ph), .o_multiply_result_low(pl), .o_zero_flag(z),
    .o_zero_flag_we(zwe), .o_instr_done(dn), .o_phase(phs));
  // ==========================================================
  // Shared tasks
  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  // Issue one word at the next decode phase, then gather done and zero-write
  task run(input logic [15:0] wd, output logic d, output logic q, output logic zv);
    int n;
    n = 0; d = 0; q = 0; zv = 0;
    @(negedge i_mclk);
    while (phs !== 2'h3 && n < 8) begin @(negedge i_mclk); n++; end
    if (n == 8) begin errors++; print_verdict(); end
    @(posedge i_mclk); i_instr <= wd; i_instr_valid <= 1'b1;
    @(posedge i_mclk); i_instr_valid <= 1'b0;
    for (n = 0; n < 7; n++) begin
      @(negedge i_mclk);
      if (zwe === 1'b1) begin q = 1; zv = z; end
      if (dn === 1'b1) d = 1;
    end
  endtask : run
  // ==========================================================
  // Core-side write of one data byte
  task load(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_ext_we <= 1'b1;
    i_ext_addr <= a;
    i_ext_data <= v;
    @(posedge i_mclk);
    i_ext_we <= 1'b0;
  endtask : load
  // Scenarios
  task t_move;
    logic d, q, zv;
    load(8'h05, 8'h11);
    run({3'h2, 5'h05, 8'h0A}, d, q, zv);
    chk("move done", d, 1'b1);
    chk("move zwe", q, 1'b1);
    chk("move zero", zv, 1'b0);
    chk("move to w", w, 8'h11);
    load(8'h01, 8'h19);
    run({3'h2, 5'h0A, 8'h00}, d, q, zv);
    chk("indirect dest", ph, 8'h11);
    load(8'h01, 8'hC0);
    run({3'h2, 5'h05, 8'hC0}, d, q, zv);
    chk("high dest done", d, 1'b1);
    run({3'h2, 5'h1F, 8'h0A}, d, q, zv);
    chk("zero byte", zv, 1'b1);
    chk("w cleared", w, 8'h00);
    run({3'h2, 5'h00, 8'h0A}, d, q, zv);
    chk("indirect src", w, 8'h11);
    $display("move test done");
  endtask : t_move
  task t_mult;
    logic d, q, zv;
    load(8'h0A, 8'hC4);
    i_zero_flag <= 1'b1;
    run(16'hBCE2, d, q, zv);
    chk("mul done", d, 1'b1);
    chk("mul zwe", q, 1'b0);
    chk("zero kept", z, 1'b1);
    chk("product", {ph, pl}, 16'hAD08);
    chk("mul w", w, 8'hC4);
    run(16'hBC00, d, q, zv);
    chk("zero product", {ph, pl}, 16'h0000);
    chk("zero mul zwe", q, 1'b0);
    $display("multiply test done");
  endtask : t_mult
  task t_store;
    logic d, q, zv;
    i_zero_flag <= 1'b0;
    run(16'h0119, d, q, zv);
    chk("store done", d, 1'b1);
    chk("store zwe", q, 1'b0);
    chk("high", ph, 8'hC4);
    chk("store zero", z, 1'b0);
    $display("store test done");
  endtask : t_store
  task t_refuse;
    logic d, q, zv;
    run(16'hFFFF, d, q, zv);
    chk("refused done", d, 1'b0);
    $display("refuse test done");
  endtask : t_refuse
  // Main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    chk("reset", {w, ph, pl, z, zwe, dn}, 16'h0000);
    i_reset_n <= 1'b1;
    t_move();
    t_mult();
    t_store();
    t_refuse();
    print_verdict();
  end
endmodule : tb_top
